// ==== logic/tmc_pkg.sv ====
// Notes on behaviour
// - Two timers, one compact and one periodic, each with a 10-bit counter.
// - Counter clock is a system ratio, high-clock ratio, subsidiary clock or pin.
// - With the pin as source the counter steps on the chosen pin edge.
// - Counter equal to a comparator raises an event, may clear counter, steer output.
// - Each timer has separate comparator A and comparator P events.
// - Compare-match output mode sets, clears or toggles the output on match.
// - PWM appears on the same output as compare-match output.
// - Periodic timer captures on its io pin; two-bit field picks rise, fall, both.
// - Single-pulse mode triggers from the periodic timer clock pin.
// - Capture may instead be triggered by the periodic timer clock pin.
// - Compact timer lacks capture and single pulse; periodic timer has both.
// - Edge-aligned PWM, adjustable in duty or in period by configuration.
// - Route bit zero gives port bit one to GPIO or the periodic timer io pin.
// - Low route pair gives port bit three to GPIO, compact output or touch key.
// - Route bit five gives port bit five to GPIO/compact clock or protection input.
// - High route pair code zero gives port bit four to GPIO/periodic clock.
// - Route bits reset to zero; unused top bit reads as zero.
// - Clock code 000 is system clock over four; 110/111 pin rise/fall.
// - Run rising clears the counter; run falling freezes it.
package tmc_pkg;

  localparam int CNT_W = 10;
  localparam int AW = 8;
  localparam int NUM_TMR = 2;
  localparam int TMR_CT = 0;
  localparam int TMR_PT = 1;
  localparam int ST_W = 2 * NUM_TMR;

  // Register byte offsets.
  localparam logic [7:0] OFS_ROUTE = 8'h00;
  localparam logic [7:0] OFS_TMR_BASE = 8'h10;
  localparam logic [7:0] OFS_TMR_STRIDE = 8'h10;
  localparam logic [7:0] SUB_CTRL = 8'h00;
  localparam logic [7:0] SUB_CCA = 8'h04;
  localparam logic [7:0] SUB_CCP = 8'h08;
  localparam logic [7:0] SUB_CNT = 8'h0C;
  localparam logic [7:0] OFS_CAPTURE = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // Timer control register layout.
  localparam int CTL_W = 18;
  localparam int CTL_RP_LSB = 0;
  localparam int CTL_RP_W = 3;
  localparam int CTL_CK_LSB = 3;
  localparam int CTL_RUN = 6;
  localparam int CTL_PAU = 7;
  localparam int CTL_MODE_LSB = 8;
  localparam int CTL_IO_LSB = 10;
  localparam int CTL_OC = 12;
  localparam int CTL_POL = 13;
  localparam int CTL_DPX = 14;
  localparam int CTL_CCLR = 15;
  localparam int CTL_CAPSRC = 16;
  localparam int CTL_SPM = 17;
  localparam int P_SHIFT = 7;
  localparam logic [CTL_W-1:0] CTL_RESET = 18'h0_0000;
  localparam logic [CTL_W-1:0] CTL_CT_MASK = 18'h0_FFFF;

  // Pin route register layout.
  localparam int RT_B0 = 0;
  localparam int RT_LP_LSB = 1;
  localparam int RT_HP_LSB = 3;
  localparam int RT_B5 = 5;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [7:0] ROUTE_MASK = 8'h7F;
  localparam logic [1:0] ROUTE_LP_CTP = 2'h1;
  localparam logic [1:0] ROUTE_HP_GPIO = 2'h0;

  // Clock source codes.
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB_A = 3'h4;
  localparam logic [2:0] CK_SUB_B = 3'h5;
  localparam logic [2:0] CK_EXT_R = 3'h6;
  localparam logic [2:0] CK_EXT_F = 3'h7;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV4_MASK = 6'h03;
  localparam logic [DIV_W-1:0] DIV16_MASK = 6'h0F;
  localparam logic [DIV_W-1:0] DIV64_MASK = 6'h3F;

  // Output and capture field codes.
  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_FORCE_OFF = 2'h0;
  localparam logic [1:0] PWM_FORCE_ON = 2'h1;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;

  typedef enum logic [1:0] {
    TMC_MODE_CMP,
    TMC_MODE_CAP,
    TMC_MODE_PWM,
    TMC_MODE_TMR
  } tmc_mode_e;

  // Byte offset of one register of timer t.
  function automatic logic [7:0] tmr_ofs(input int t, input logic [7:0] sub);
    tmr_ofs = 8'(OFS_TMR_BASE + OFS_TMR_STRIDE * t + sub);
  endfunction

  // Counter step enable for a clock select code.
  function automatic logic src_tick(input logic [2:0] sel, input logic e4,
                                    input logic e16, input logic e64, input logic es,
                                    input logic er, input logic ef);
    case (sel)
      CK_SYS4: src_tick = e4;
      CK_SYS: src_tick = 1'b1;
      CK_H16: src_tick = e16;
      CK_H64: src_tick = e64;
      CK_SUB_A, CK_SUB_B: src_tick = es;
      CK_EXT_R: src_tick = er;
      CK_EXT_F: src_tick = ef;
      default: src_tick = 1'b0;
    endcase
  endfunction

endpackage

// ==== logic/tmc_top.sv ====
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module tmc_top
  import tmc_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Subsidiary clock as a one-cycle enable.
  input wire logic sub_clk_en,
  // Port pins and the general-purpose port logic behind them.
  input wire logic port_bit_one_pin_in,
  output logic port_bit_one_pin_out,
  output logic port_bit_one_pin_oe,
  input wire logic gpio_one_out,
  input wire logic gpio_one_oe,
  input wire logic port_bit_three_pin_in,
  output logic port_bit_three_pin_out,
  output logic port_bit_three_pin_oe,
  input wire logic gpio_three_out,
  input wire logic gpio_three_oe,
  input wire logic port_bit_four_pin_in,
  input wire logic port_bit_five_pin_in,
  // Route selection for the other pin functions.
  output logic [7:0] pin_function_select_q,
  // Timer events and waveforms.
  output logic ct_int_a,
  output logic ct_int_p,
  output logic pt_int_a,
  output logic pt_int_p,
  output logic compact_timer_output_pin,
  output logic periodic_timer_io_pin_out
);

  logic addr_phase;
  logic wr_pend_reg;
  logic [AW-1:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_mux;
  logic [7:0] route_reg;
  logic [CTL_W-1:0] ctrl_reg [NUM_TMR];
  logic [CW-1:0] cca_reg [NUM_TMR];
  logic [CW-1:0] cnt_reg [NUM_TMR];
  logic [CW-1:0] pt_ccp_reg;
  logic [CW-1:0] pt_cap_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  logic [DIV_W-1:0] div_reg;
  logic en4;
  logic en16;
  logic en64;
  logic evt_a [NUM_TMR];
  logic evt_p [NUM_TMR];
  logic tmr_pin [NUM_TMR];
  logic int_a_reg [NUM_TMR];
  logic int_p_reg [NUM_TMR];
  logic pt_io_in;
  logic ct_clk_pin;
  logic pt_clk_pin;
  logic cap_src;
  logic cap_prev_reg;
  logic pt_cap_evt;
  tmc_mode_e pt_mode;

  // Write to one decoded offset in the data phase.
  function automatic logic wr_hit(input logic pend, input logic [AW-1:0] a,
                                  input logic [7:0] ofs);
    wr_hit = pend && (a == ofs);
  endfunction

  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign addr_phase = hsel && hready && htrans[1];

  // Address phase of a write is held for its one-cycle data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase)
      begin
        wr_addr_reg <= haddr[AW-1:0];
      end
    end
  end

  // Read mux; unmapped offsets and unimplemented bits read as zero.
  always_comb
  begin
    rd_mux = '0;
    if (haddr[AW-1:0] == OFS_ROUTE)
    begin
      rd_mux = 32'(route_reg & ROUTE_MASK);
    end
    if (haddr[AW-1:0] == OFS_CAPTURE)
    begin
      rd_mux = 32'(pt_cap_reg);
    end
    if (haddr[AW-1:0] == OFS_STATUS)
    begin
      rd_mux = 32'(status_reg);
    end
    if (haddr[AW-1:0] == tmr_ofs(TMR_PT, SUB_CCP))
    begin
      rd_mux = 32'(pt_ccp_reg);
    end
    for (int t = 0; t < NUM_TMR; t++)
    begin
      if (haddr[AW-1:0] == tmr_ofs(t, SUB_CTRL))
      begin
        rd_mux = 32'(ctrl_reg[t]);
      end
      if (haddr[AW-1:0] == tmr_ofs(t, SUB_CCA))
      begin
        rd_mux = 32'(cca_reg[t]);
      end
      if (haddr[AW-1:0] == tmr_ofs(t, SUB_CNT))
      begin
        rd_mux = 32'(cnt_reg[t]);
      end
    end
  end

  // Read data is sampled in the address phase so it leaves a flip-flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= '0;
    end
    else if (addr_phase && !hwrite)
    begin
      hrdata_reg <= rd_mux;
    end
  end

  // Pin route register; bit seven is not stored.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      route_reg <= ROUTE_RESET;
    end
    else if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_ROUTE))
    begin
      route_reg <= hwdata[7:0] & ROUTE_MASK;
    end
  end

  assign pin_function_select_q = route_reg;

  // Period comparator of the periodic timer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pt_ccp_reg <= '0;
    end
    else if (wr_hit(wr_pend_reg, wr_addr_reg, tmr_ofs(TMR_PT, SUB_CCP)))
    begin
      pt_ccp_reg <= hwdata[CW-1:0];
    end
  end

  // Shared prescaler; fsys and the high clock both run at hclk here.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  assign en4 = (div_reg & DIV4_MASK) == DIV4_MASK;
  assign en16 = (div_reg & DIV16_MASK) == DIV16_MASK;
  assign en64 = (div_reg & DIV64_MASK) == DIV64_MASK;

  // Pin routing; an unrouted timer input reads low.
  assign pt_io_in = route_reg[RT_B0] && port_bit_one_pin_in;
  assign ct_clk_pin = !route_reg[RT_B5] && port_bit_five_pin_in;
  assign pt_clk_pin = (route_reg[RT_HP_LSB +: 2] == ROUTE_HP_GPIO)
                      && port_bit_four_pin_in;
  assign pt_mode = tmc_mode_e'(ctrl_reg[TMR_PT][CTL_MODE_LSB +: 2]);

  // The io pin turns into an input while the periodic timer captures.
  always_comb
  begin
    port_bit_one_pin_out = route_reg[RT_B0] ? tmr_pin[TMR_PT] : gpio_one_out;
    port_bit_one_pin_oe = route_reg[RT_B0] ? (pt_mode != TMC_MODE_CAP) : gpio_one_oe;
    if (route_reg[RT_LP_LSB +: 2] == ROUTE_LP_CTP)
    begin
      port_bit_three_pin_out = tmr_pin[TMR_CT];
      port_bit_three_pin_oe = 1'b1;
    end
    else
    begin
      port_bit_three_pin_out = gpio_three_out;
      port_bit_three_pin_oe = gpio_three_oe;
    end
  end

  // Capture edge detection on the io pin or the clock pin.
  assign cap_src = ctrl_reg[TMR_PT][CTL_CAPSRC] ? pt_clk_pin : pt_io_in;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_prev_reg <= 1'b0;
    end
    else
    begin
      cap_prev_reg <= cap_src;
    end
  end

  always_comb
  begin
    pt_cap_evt = 1'b0;
    case (ctrl_reg[TMR_PT][CTL_IO_LSB +: 2])
      CAP_RISE: pt_cap_evt = cap_src && !cap_prev_reg;
      CAP_FALL: pt_cap_evt = !cap_src && cap_prev_reg;
      CAP_BOTH: pt_cap_evt = cap_src != cap_prev_reg;
      default: pt_cap_evt = 1'b0;
    endcase
    if (!ctrl_reg[TMR_PT][CTL_RUN] || pt_mode != TMC_MODE_CAP)
    begin
      pt_cap_evt = 1'b0;
    end
  end

  // Captured counter value.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pt_cap_reg <= '0;
    end
    else if (pt_cap_evt)
    begin
      pt_cap_reg <= cnt_reg[TMR_PT];
    end
  end

  // Sticky event flags, write one to clear; a new event beats the clear.
  assign st_set = {evt_p[TMR_PT], evt_a[TMR_PT], evt_p[TMR_CT], evt_a[TMR_CT]};
  assign st_clr = wr_hit(wr_pend_reg, wr_addr_reg, OFS_STATUS) ? hwdata[ST_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_reg <= '0;
    end
    else
    begin
      status_reg <= (status_reg & ~st_clr) | st_set;
    end
  end

  for (genvar t = 0; t < NUM_TMR; t++)
  begin : g_tmr
    localparam bit IS_PT = (t == TMR_PT);
    logic [CTL_W-1:0] ctl;
    logic ext_pin;
    logic ext_prev_reg;
    logic run_prev_reg;
    logic run_rise;
    logic sp_mode;
    logic sp_act_reg;
    logic trig;
    logic tick;
    logic clr;
    logic hit_a;
    logic hit_p;
    logic out_reg;
    logic [CW-1:0] nxt;
    logic [CW-1:0] pval;
    logic [CW-1:0] duty;
    logic [1:0] io;
    tmc_mode_e mode;

    assign ctl = ctrl_reg[t];
    assign mode = tmc_mode_e'(ctl[CTL_MODE_LSB +: 2]);
    assign io = ctl[CTL_IO_LSB +: 2];
    assign ext_pin = IS_PT ? pt_clk_pin : ct_clk_pin;
    assign run_rise = ctl[CTL_RUN] && !run_prev_reg;
    assign sp_mode = IS_PT && (mode == TMC_MODE_PWM) && ctl[CTL_SPM];
    assign trig = sp_mode && ctl[CTL_RUN] && !sp_act_reg && ext_pin && !ext_prev_reg;
    assign tick = ctl[CTL_RUN] && !ctl[CTL_PAU] && (!sp_mode || sp_act_reg)
                  && src_tick(ctl[CTL_CK_LSB +: 3], en4, en16, en64, sub_clk_en,
                              ext_pin && !ext_prev_reg,
                              !ext_pin && ext_prev_reg);
    assign nxt = cnt_reg[t] + CW'(1);
    // The compact period code lines up with the three top counter bits.
    assign pval = IS_PT ? pt_ccp_reg : (CW'(ctl[CTL_RP_LSB +: CTL_RP_W]) << P_SHIFT);
    assign hit_a = tick && (nxt == cca_reg[t]);
    assign hit_p = tick && (nxt == pval);
    assign duty = ctl[CTL_DPX] ? pval : cca_reg[t];
    assign evt_a[t] = hit_a || (IS_PT && pt_cap_evt);
    assign evt_p[t] = hit_p;
    assign tmr_pin[t] = out_reg ^ ctl[CTL_POL];

    // Counter clear source per mode.
    always_comb
    begin
      if (sp_mode)
      begin
        clr = hit_a;
      end
      else if (mode == TMC_MODE_PWM)
      begin
        clr = ctl[CTL_DPX] ? hit_a : hit_p;
      end
      else
      begin
        clr = ctl[CTL_CCLR] ? hit_a : hit_p;
      end
    end

    // Control and comparator A; the compact timer keeps no capture or pulse bits.
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        ctrl_reg[t] <= CTL_RESET;
        cca_reg[t] <= '0;
      end
      else
      begin
        if (wr_hit(wr_pend_reg, wr_addr_reg, tmr_ofs(t, SUB_CTRL)))
        begin
          ctrl_reg[t] <= IS_PT ? hwdata[CTL_W-1:0] : (hwdata[CTL_W-1:0] & CTL_CT_MASK);
        end
        if (wr_hit(wr_pend_reg, wr_addr_reg, tmr_ofs(t, SUB_CCA)))
        begin
          cca_reg[t] <= hwdata[CW-1:0];
        end
      end
    end

    // Counter: cleared when run rises or a pulse starts, frozen when run is low.
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        cnt_reg[t] <= '0;
        run_prev_reg <= 1'b0;
        ext_prev_reg <= 1'b0;
      end
      else
      begin
        run_prev_reg <= ctl[CTL_RUN];
        ext_prev_reg <= ext_pin;
        if (run_rise || trig)
        begin
          cnt_reg[t] <= '0;
        end
        else if (tick)
        begin
          cnt_reg[t] <= clr ? '0 : nxt;
        end
      end
    end

    // Single pulse runs from the trigger edge to the comparator A match.
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        sp_act_reg <= 1'b0;
      end
      else if (!sp_mode || !ctl[CTL_RUN])
      begin
        sp_act_reg <= 1'b0;
      end
      else if (trig)
      begin
        sp_act_reg <= 1'b1;
      end
      else if (hit_a)
      begin
        sp_act_reg <= 1'b0;
      end
    end

    // Output level before polarity; PWM shares this pin with compare output.
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        out_reg <= 1'b0;
      end
      else if (run_rise)
      begin
        out_reg <= ctl[CTL_OC];
      end
      else if (ctl[CTL_RUN])
      begin
        case (mode)
          TMC_MODE_CMP:
          begin
            if (hit_a)
            begin
              case (io)
                IO_LOW: out_reg <= 1'b0;
                IO_HIGH: out_reg <= 1'b1;
                IO_TOGGLE: out_reg <= !out_reg;
                default: out_reg <= out_reg;
              endcase
            end
          end
          TMC_MODE_PWM:
          begin
            if (sp_mode)
            begin
              if (trig)
              begin
                out_reg <= ctl[CTL_OC];
              end
              else if (hit_a)
              begin
                out_reg <= !ctl[CTL_OC];
              end
            end
            else if (io == PWM_FORCE_OFF)
            begin
              out_reg <= !ctl[CTL_OC];
            end
            else if (io == PWM_FORCE_ON)
            begin
              out_reg <= ctl[CTL_OC];
            end
            else
            begin
              out_reg <= (cnt_reg[t] < duty) ? ctl[CTL_OC] : !ctl[CTL_OC];
            end
          end
          default: out_reg <= out_reg;
        endcase
      end
    end

    // One-cycle event pulses, one flip-flop behind the match.
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        int_a_reg[t] <= 1'b0;
        int_p_reg[t] <= 1'b0;
      end
      else
      begin
        int_a_reg[t] <= evt_a[t];
        int_p_reg[t] <= evt_p[t];
      end
    end
  end

  assign ct_int_a = int_a_reg[TMR_CT];
  assign ct_int_p = int_p_reg[TMR_CT];
  assign pt_int_a = int_a_reg[TMR_PT];
  assign pt_int_p = int_p_reg[TMR_PT];
  assign compact_timer_output_pin = tmr_pin[TMR_CT];
  assign periodic_timer_io_pin_out = tmr_pin[TMR_PT];

endmodule // tmc_top

// ==== tb/tmc_sva.sv ====
`timescale 1ns/10ps
module tmc_sva
  import tmc_pkg::*;
(
  // Bus side.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pin side.
  input wire logic gpio_one_out,
  input wire logic gpio_one_oe,
  input wire logic gpio_three_out,
  input wire logic gpio_three_oe,
  input wire logic port_bit_one_pin_out,
  input wire logic port_bit_one_pin_oe,
  input wire logic port_bit_three_pin_out,
  input wire logic port_bit_three_pin_oe,
  input wire logic [7:0] pin_function_select_q,
  input wire logic compact_timer_output_pin,
  input wire logic periodic_timer_io_pin_out
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Address phases seen by the slave.
  logic take;
  assign take = hsel && hready && htrans[1];

  a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("slave answered other than ready and okay");
  a_route_top_zero: assert property (pin_function_select_q[7] == 1'b0)
    else $error("route top bit not zero");
  a_route_write: assert property (take && hwrite && haddr[7:0] == OFS_ROUTE
    |-> ##2 pin_function_select_q == ($past(hwdata[7:0]) & 8'h7F))
    else $error("route write not taken");
  a_read_stands: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_port1_gpio: assert property (!pin_function_select_q[RT_B0]
    |-> port_bit_one_pin_out == gpio_one_out && port_bit_one_pin_oe == gpio_one_oe)
    else $error("port one not passed to gpio");
  a_port1_timer: assert property (pin_function_select_q[RT_B0]
    |-> port_bit_one_pin_out == periodic_timer_io_pin_out)
    else $error("port one not driven by periodic timer");
  a_port3_gpio: assert property (pin_function_select_q[2:1] != ROUTE_LP_CTP
    |-> port_bit_three_pin_out == gpio_three_out && port_bit_three_pin_oe == gpio_three_oe)
    else $error("port three not passed to gpio");
  a_port3_timer: assert property (pin_function_select_q[2:1] == ROUTE_LP_CTP
    |-> port_bit_three_pin_out == compact_timer_output_pin && port_bit_three_pin_oe)
    else $error("port three not driven by compact timer");
endmodule // tmc_sva

// ==== tb/tmc_pin_model.sv ====
`timescale 1ns/10ps
module tmc_pin_model
(
  // Clock, reset and pulse requests.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] pulse_req,
  // Pins toward the block.
  output logic port_bit_one_pin_in,
  output logic port_bit_four_pin_in,
  output logic port_bit_five_pin_in
);
  logic [1:0] cnt_reg [3];

  // Each request gives two cycles high then two low, so both edges are seen.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!hresetn) cnt_reg[i] <= 2'h0;
      else if (pulse_req[i]) cnt_reg[i] <= 2'h3;
      else if (cnt_reg[i] != 2'h0) cnt_reg[i] <= cnt_reg[i] - 2'h1;
    end
  end

  // Pins rest low between pulses.
  assign port_bit_one_pin_in = cnt_reg[0][1];
  assign port_bit_four_pin_in = cnt_reg[1][1];
  assign port_bit_five_pin_in = cnt_reg[2][1];
endmodule // tmc_pin_model

// ==== tb/tb_tmc_top.sv ====
`timescale 1ns/10ps
module tb_tmc_top;
  import tmc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sub_clk_en = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, pulse_req = 3'h0;
  logic hreadyout, hresp, p1_in, p4_in, p5_in, p1_out, p1_oe, p3_out, p3_oe;
  logic g1_out = 1'b0, g1_oe = 1'b0, g3_out = 1'b0, g3_oe = 1'b0, lvl, rd_ph = 1'b0;
  logic ct_a, ct_p, pt_a, pt_p, ct_pin, pt_pin;
  logic [7:0] route_q;
  logic [31:0] exp_q [$];
  int fail_count = 0, checks = 0, cyc = 0, pt_cnt = 0, n, seed = 18165;

  // Clock at 250 MHz.
  always #2 hclk = ~hclk;

  tmc_top tmc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sub_clk_en(sub_clk_en),
    .port_bit_one_pin_in(p1_in), .port_bit_one_pin_out(p1_out), .port_bit_one_pin_oe(p1_oe),
    .gpio_one_out(g1_out), .gpio_one_oe(g1_oe), .port_bit_three_pin_in(1'b0),
    .port_bit_three_pin_out(p3_out), .port_bit_three_pin_oe(p3_oe), .gpio_three_out(g3_out),
    .gpio_three_oe(g3_oe), .port_bit_four_pin_in(p4_in), .port_bit_five_pin_in(p5_in),
    .pin_function_select_q(route_q), .ct_int_a(ct_a), .ct_int_p(ct_p), .pt_int_a(pt_a),
    .pt_int_p(pt_p), .compact_timer_output_pin(ct_pin), .periodic_timer_io_pin_out(pt_pin));

  tmc_pin_model tmc_pin_model_inst (.hclk(hclk), .hresetn(hresetn), .pulse_req(pulse_req),
    .port_bit_one_pin_in(p1_in), .port_bit_four_pin_in(p4_in), .port_bit_five_pin_in(p5_in));

  task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic compare_bit(input logic got, input logic exp);
    compare_word({31'h0, got}, {31'h0, exp});
  endtask

  // One single AHB transfer; a read leaves its expectation in the queue.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    if (!w) exp_q.push_back(d);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0000_0000;
    rd_ph <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask

  // Read data are taken at the edge that ends the data phase.
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout === 1'b1) compare_word(hrdata, exp_q.pop_front());
    if (pt_a === 1'b1) pt_cnt++;
    sub_clk_en <= 1'($random(seed));
  end

  task automatic pulse(input int idx, input int cnt);
    repeat (cnt)
    begin
      @(posedge hclk);
      pulse_req[idx] <= 1'b1;
      @(posedge hclk);
      pulse_req[idx] <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask

  task automatic next_int(output int k);
    k = 0;
    do
    begin
      @(posedge hclk);
      #1;
      k++;
    end while (ct_a !== 1'b1 && k < 40);
  endtask

  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang is cut short well beyond the run's length.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(OFS_ROUTE, 0, 32'h0000_0000);
    bus(8'h10, 0, 32'h0000_0000);
    bus(OFS_STATUS, 0, 32'h0000_0000);
    bus(OFS_ROUTE, 1, 32'h0000_00FF);
    bus(OFS_ROUTE, 0, 32'h0000_007F);
    bus(8'h18, 1, 32'hFFFF_FFFF);
    bus(8'h18, 0, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      bus(8'h10, 1, 32'(i) << 3);
      bus(8'h10, 0, 32'(i) << 3);
    end
    rv = $random(seed);
    bus(8'h14, 1, rv);
    bus(8'h14, 0, rv & 32'h0000_03FF);
    bus(OFS_ROUTE, 1, 32'h0000_0000);
    repeat (4)
    begin
      {g1_out, g1_oe, g3_out, g3_oe} <= 4'($random(seed));
      @(posedge hclk);
      #1;
      compare_bit(p1_out, g1_out);
      compare_bit(p3_oe, g3_oe);
    end
    bus(OFS_ROUTE, 1, 32'h0000_0003);
    @(posedge hclk);
    #1;
    compare_bit(p3_out, ct_pin);
    compare_bit(p3_oe, 1'b1);
    compare_bit(p1_oe, 1'b1);
    // Compact timer: hclk source, clear on A, toggle on match, A of 5.
    bus(8'h14, 1, 32'h0000_0005);
    bus(8'h10, 1, 32'h0003_8C48);
    bus(8'h10, 0, 32'h0000_8C48);
    next_int(n);
    lvl = ct_pin;
    next_int(n);
    compare_word(32'(n), 32'h0000_0005);
    compare_bit(ct_pin, ~lvl);
    bus(8'h10, 1, 32'h0000_8C08);
    bus(8'h10, 1, 32'h0000_8CC8);
    bus(8'h1C, 0, 32'h0000_0000);
    compare_bit(ct_pin, 1'b0);
    bus(OFS_STATUS, 0, 32'h0000_0001);
    bus(OFS_STATUS, 1, 32'h0000_000F);
    bus(OFS_STATUS, 0, 32'h0000_0000);
    // Pin clock on rising, then on falling edges, then with the pin routed away.
    bus(OFS_ROUTE, 1, 32'h0000_0000);
    bus(8'h10, 1, 32'h0000_0370);
    pulse(2, 7);
    bus(8'h1C, 0, 32'h0000_0007);
    bus(8'h10, 1, 32'h0000_0338);
    bus(8'h10, 1, 32'h0000_0378);
    pulse(2, 3);
    bus(8'h1C, 0, 32'h0000_0003);
    bus(OFS_ROUTE, 1, 32'h0000_0020);
    bus(8'h10, 1, 32'h0000_0338);
    bus(8'h10, 1, 32'h0000_0378);
    pulse(2, 4);
    bus(8'h1C, 0, 32'h0000_0000);
    // Periodic capture on rising edges of its io pin.
    bus(OFS_ROUTE, 1, 32'h0000_0001);
    bus(8'h20, 1, 32'h0000_0148);
    @(posedge hclk);
    #1;
    compare_bit(p1_oe, 1'b0);
    pulse(0, 1);
    compare_word(32'(pt_cnt), 32'h0000_0001);
    bus(OFS_CAPTURE, 0, 32'h0000_0002);
    // Capture from the clock pin; the compact A match of the pin count left bit zero set.
    bus(8'h20, 1, 32'h0001_0148);
    pulse(1, 1);
    compare_word(32'(pt_cnt), 32'h0000_0002);
    bus(OFS_STATUS, 0, 32'h0000_0005);
    repeat (2) @(posedge hclk);
    final_report();
  end
endmodule // tb_tmc_top

bind tmc_top tmc_sva tmc_sva_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_one_out(gpio_one_out),
  .gpio_one_oe(gpio_one_oe), .gpio_three_out(gpio_three_out), .gpio_three_oe(gpio_three_oe),
  .port_bit_one_pin_out(port_bit_one_pin_out), .port_bit_one_pin_oe(port_bit_one_pin_oe),
  .port_bit_three_pin_out(port_bit_three_pin_out),
  .port_bit_three_pin_oe(port_bit_three_pin_oe), .pin_function_select_q(pin_function_select_q),
  .compact_timer_output_pin(compact_timer_output_pin),
  .periodic_timer_io_pin_out(periodic_timer_io_pin_out));
